// *** design/dtg_core.sv ***
// Purpose: Dual-tone transceiver digital core: receive qualification,
//   status flags, interrupt pin and tone synthesiser control
// Assumes: Detector delivers frequency-present level and row/column index
// Notes: Avalon-MM slave, every access answered in two cycles
// Function
// RULE1: A single-tone mode produces only one tone, from the low or the high group.
// RULE2: Divider settings give 699.1/766.2/847.4/948.0 Hz and 1215.9/1331.7/1471.9/1645.0 Hz.
// RULE3: A tone that vanishes before the present guard time leaves the data untouched and flags nothing.
// RULE4: A tone pair present for the full present guard time is decoded and its code latched.
// RULE5: After a tone ends and the absent guard time passes, the latched code stays until the next latch.
// RULE6: A dropout shorter than the absent guard time belongs to the same tone, with no new latch.
// RULE7: Status bit 3 is low while a validated tone is present, from present guard to absent guard.
// RULE8: Status bit 2 is set on a new latch and cleared by reading status.
// RULE9: The interrupt asserts on a new latch and deasserts when status is read.
// RULE10: The early detect flag follows detected frequencies without any guard delay.
// RULE11: Each tone period has 32 equal segments whose length alone sets the frequency.
// RULE12: Received codes use the same digit mapping as transmit codes.
// RULE13: In call-progress mode the receiver neither detects nor latches digits.
// RULE14: The interrupt pin pulls low only with interrupt enable set and tone mode selected; the code also does so in CP mode while the comparator is low.
// RULE15: A latch in the same cycle as a status read wins, so flag and interrupt stay set.
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
module dtg_core
  import dtg_pkg::*;
#(
  parameter int GUARD_PRESENT_N = GUARD_PRESENT_CYC,
  parameter int GUARD_ABSENT_N = GUARD_ABSENT_CYC,
  parameter int BURST_N = BURST_CYC,
  parameter int BURST_CP_N = BURST_CP_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Tone detector
  input wire logic tone_present_i,
  input wire dtg_pair_t tone_pair_i,
  input wire logic cp_comparator_i,
  // Receive outputs
  output logic early_detect_flag_o,
  output logic guard_timing_pin_o,
  output logic [3:0] rx_code_bits_o,
  // Open-drain interrupt / call-progress pin
  output logic irq_or_tone_out_o,
  output logic irq_or_tone_out_oen_o,
  // Tone synthesiser
  output logic low_tone_on_o,
  output logic high_tone_on_o,
  output logic [PH_W-1:0] low_phase_o,
  output logic [PH_W-1:0] high_phase_o
);
  dtg_ctrl_t ctrl_r;
  logic [3:0] tx_code_r;
  logic [3:0] rx_code_r;
  logic dv_r;
  logic irq_r;
  logic txrdy_r;
  logic ack_r;
  logic [31:0] rdata_r;
  dtg_rx_st_t rx_st_r;
  dtg_rx_st_t rx_st_nxt;
  dtg_bs_st_t bs_st_r;
  dtg_bs_st_t bs_st_nxt;

  // Bus decode
  wire logic req = avs_read_i || avs_write_i;
  wire logic take = req && ack_r;
  wire logic wr_data = take && avs_write_i && (avs_address_i == REG_DATA);
  wire logic wr_ctrl = take && avs_write_i && (avs_address_i == REG_CTRL_STAT);
  wire logic rd_stat = take && avs_read_i && (avs_address_i == REG_CTRL_STAT);
  wire logic [3:0] status;
  wire logic [31:0] rdata_mux;

  // Receive qualification
  wire logic tone_mode = !ctrl_r.call_progress_select;
  wire logic det = tone_present_i && tone_mode; // RULE13
  wire logic rx_tmr_clr;
  wire logic rx_tmr_run;
  wire logic [TMR_W-1:0] rx_tmr_len;
  wire logic rx_tmr_done;
  wire logic latch;
  wire logic steer_low;

  // Burst sequencing
  wire logic bs_tmr_clr;
  wire logic bs_tmr_run;
  wire logic [TMR_W-1:0] bs_tmr_len;
  wire logic bs_tmr_done;
  wire logic txrdy_set;
  wire logic irq_set;

  // Tone synthesiser
  wire dtg_pair_t tx_pair = code_to_pair(tx_code_r);
  wire logic tone_gate;
  wire logic low_en;
  wire logic high_en;
  wire logic [DIV_W-1:0] low_len;
  wire logic [DIV_W-1:0] high_len;
  wire logic [DIV_W-1:0] seg_tab [8];

  assign avs_waitrequest_o = req && !ack_r;
  assign avs_readdata_o = rdata_r;
  assign status = {steer_low ? 1'b0 : 1'b1, dv_r, txrdy_r, irq_r}; // RULE7
  assign rdata_mux = (avs_address_i == REG_DATA) ? {28'h0000000, rx_code_r} :
                     (avs_address_i == REG_CTRL_STAT) ? {28'h0000000, status} :
                     (avs_address_i == REG_CTRL_RB) ? {26'h0, ctrl_r} : 32'h00000000;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= req && !ack_r;
      if (avs_read_i && !ack_r) begin
        rdata_r <= rdata_mux;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      tx_code_r <= CODE_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= avs_writedata_i[5:0];
      end
      if (wr_data) begin
        tx_code_r <= avs_writedata_i[3:0];
      end
    end
  end

  // Receive state machine
  assign rx_tmr_clr = (rx_st_r != rx_st_nxt) || (rx_st_r == RX_IDLE) || (rx_st_r == RX_HELD);
  assign rx_tmr_run = (rx_st_r == RX_QUAL) || (rx_st_r == RX_DROP);
  assign rx_tmr_len = (rx_st_r == RX_QUAL) ? TMR_W'(GUARD_PRESENT_N) : TMR_W'(GUARD_ABSENT_N);
  assign latch = (rx_st_r == RX_QUAL) && det && rx_tmr_done; // RULE4
  assign steer_low = (rx_st_r == RX_HELD) || (rx_st_r == RX_DROP); // RULE7

  always_comb begin
    rx_st_nxt = rx_st_r;
    case (rx_st_r)
      RX_IDLE: begin
        if (det) begin
          rx_st_nxt = RX_QUAL;
        end
      end
      RX_QUAL: begin
        if (!det) begin
          rx_st_nxt = RX_IDLE; // RULE3
        end else if (rx_tmr_done) begin
          rx_st_nxt = RX_HELD; // RULE4
        end
      end
      RX_HELD: begin
        if (!det) begin
          rx_st_nxt = RX_DROP;
        end
      end
      RX_DROP: begin
        if (det) begin
          rx_st_nxt = RX_HELD; // RULE6
        end else if (rx_tmr_done) begin
          rx_st_nxt = RX_IDLE; // RULE5
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_st_r <= RX_IDLE;
      rx_code_r <= CODE_RST;
    end else begin
      rx_st_r <= rx_st_nxt;
      if (latch) begin
        rx_code_r <= pair_to_code(tone_pair_i); // RULE12
      end
    end
  end

  dtg_guard_tmr u_rx_tmr (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clr_i(rx_tmr_clr),
    .run_i(rx_tmr_run),
    .len_i(rx_tmr_len),
    .done_o(rx_tmr_done)
  );

  // Burst: tone on, pause, then transmitter ready
  assign bs_tmr_clr = (bs_st_r != bs_st_nxt) || (bs_st_r == BS_IDLE);
  assign bs_tmr_run = (bs_st_r == BS_TONE) || (bs_st_r == BS_PAUSE);
  assign bs_tmr_len = ctrl_r.call_progress_select ? TMR_W'(BURST_CP_N) : TMR_W'(BURST_N);
  assign txrdy_set = (bs_st_r == BS_PAUSE) && bs_tmr_done;

  always_comb begin
    bs_st_nxt = bs_st_r;
    case (bs_st_r)
      BS_IDLE: begin
        if (wr_data && ctrl_r.burst) begin
          bs_st_nxt = BS_TONE;
        end
      end
      BS_TONE: begin
        if (bs_tmr_done) begin
          bs_st_nxt = BS_PAUSE;
        end
      end
      BS_PAUSE: begin
        if (bs_tmr_done) begin
          bs_st_nxt = BS_IDLE;
        end
      end
      default: bs_st_nxt = BS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bs_st_r <= BS_IDLE;
    end else begin
      bs_st_r <= bs_st_nxt;
    end
  end

  dtg_guard_tmr u_bs_tmr (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clr_i(bs_tmr_clr),
    .run_i(bs_tmr_run),
    .len_i(bs_tmr_len),
    .done_o(bs_tmr_done)
  );

  // Sticky flags; set wins, and a read only clears what it reported
  assign irq_set = ctrl_r.irq_en && tone_mode && (latch || (txrdy_set && ctrl_r.burst)); // RULE14

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dv_r <= 1'b0;
      irq_r <= 1'b0;
      txrdy_r <= 1'b0;
    end else begin
      dv_r <= latch || (dv_r && !(rd_stat && rdata_r[ST_DV])); // RULE8 RULE15
      irq_r <= irq_set || (irq_r && !(rd_stat && rdata_r[ST_IRQ])); // RULE9 RULE15
      txrdy_r <= txrdy_set || (txrdy_r && !(rd_stat && rdata_r[ST_TXRDY]));
    end
  end

  // Receive-side pins
  assign early_detect_flag_o = det; // RULE10
  assign guard_timing_pin_o = steer_low;
  assign rx_code_bits_o = rx_code_r;

  // Open drain: pin low when enable low; with interrupt enable set, CP mode shows the comparator
  assign irq_or_tone_out_o = 1'b0;
  assign irq_or_tone_out_oen_o = ctrl_r.irq_en && (tone_mode ? irq_r : !cp_comparator_i) ? 1'b0 : 1'b1; // RULE14

  // Tone synthesiser
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_seg
      assign seg_tab[gi] = seg_len(gi); // RULE2
    end
  endgenerate

  assign tone_gate = ctrl_r.tone_out_en && (!ctrl_r.burst || (bs_st_r == BS_TONE));
  assign low_en = tone_gate && !(ctrl_r.single_tone && ctrl_r.single_high); // RULE1
  assign high_en = tone_gate && !(ctrl_r.single_tone && !ctrl_r.single_high); // RULE1
  assign low_len = seg_tab[{1'b0, tx_pair.row}];
  assign high_len = seg_tab[{1'b1, tx_pair.col}];
  assign low_tone_on_o = low_en;
  assign high_tone_on_o = high_en;

  dtg_tone_chan u_low (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(low_en),
    .seg_len_i(low_len),
    .phase_o(low_phase_o)
  );

  dtg_tone_chan u_high (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .en_i(high_en),
    .seg_len_i(high_len),
    .phase_o(high_phase_o)
  );
endmodule

// *** design/dtg_pkg.sv ***
// Purpose: Shared constants, types and code mapping for the dual-tone core
// Assumes: 200 MHz system clock
// Notes: Register offsets are byte addresses; Avalon address is the word index
package dtg_pkg;
  localparam int CLK_HZ = 200000000;
  localparam int CLK_MHZ = CLK_HZ / 1000000;
  localparam int SEGS_PER_PERIOD = 32;
  localparam int DIV_W = 14;
  localparam int PH_W = 5;
  localparam int TMR_W = 25;
  // Times in microseconds
  localparam int GUARD_PRESENT_US = 40000;
  localparam int GUARD_ABSENT_US = 40000;
  localparam int BURST_US = 51000;
  localparam int BURST_CP_US = 102000;
  localparam int GUARD_PRESENT_CYC = GUARD_PRESENT_US * CLK_MHZ;
  localparam int GUARD_ABSENT_CYC = GUARD_ABSENT_US * CLK_MHZ;
  localparam int BURST_CYC = BURST_US * CLK_MHZ;
  localparam int BURST_CP_CYC = BURST_CP_US * CLK_MHZ;
  // Actual tone frequencies in tenths of a hertz
  localparam int FREQ_DHZ [8] = '{6991, 7662, 8474, 9480, 12159, 13317, 14719, 16450};
  // Avalon word indices (byte offsets 0x0, 0x4, 0x8)
  localparam logic [1:0] REG_DATA = 2'h0;
  localparam logic [1:0] REG_CTRL_STAT = 2'h1;
  localparam logic [1:0] REG_CTRL_RB = 2'h2;
  // Status bit positions
  localparam int ST_IRQ = 0;
  localparam int ST_TXRDY = 1;
  localparam int ST_DV = 2;
  localparam int ST_DSTEER = 3;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [3:0] CODE_RST = 4'h0;

  typedef struct packed {
    logic single_high;
    logic single_tone;
    logic burst;
    logic irq_en;
    logic call_progress_select;
    logic tone_out_en;
  } dtg_ctrl_t;

  typedef struct packed {
    logic [1:0] row;
    logic [1:0] col;
  } dtg_pair_t;

  typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_QUAL = 2'h1, RX_HELD = 2'h3, RX_DROP = 2'h2} dtg_rx_st_t;
  typedef enum logic [1:0] {BS_IDLE = 2'h0, BS_TONE = 2'h1, BS_PAUSE = 2'h3} dtg_bs_st_t;

  function automatic logic [DIV_W-1:0] seg_len(input int idx);
    longint num;
    num = longint'(CLK_HZ) * 10 + longint'(SEGS_PER_PERIOD / 2) * FREQ_DHZ[idx];
    return DIV_W'(num / (longint'(SEGS_PER_PERIOD) * FREQ_DHZ[idx]));
  endfunction

  // Four-bit digit code to row/column pair
  function automatic dtg_pair_t code_to_pair(input logic [3:0] c);
    case (c)
      4'h1: return '{2'h0, 2'h0};
      4'h2: return '{2'h0, 2'h1};
      4'h3: return '{2'h0, 2'h2};
      4'h4: return '{2'h1, 2'h0};
      4'h5: return '{2'h1, 2'h1};
      4'h6: return '{2'h1, 2'h2};
      4'h7: return '{2'h2, 2'h0};
      4'h8: return '{2'h2, 2'h1};
      4'h9: return '{2'h2, 2'h2};
      4'hA: return '{2'h3, 2'h1};
      4'hB: return '{2'h3, 2'h0};
      4'hC: return '{2'h3, 2'h2};
      4'hD: return '{2'h0, 2'h3};
      4'hE: return '{2'h1, 2'h3};
      4'hF: return '{2'h2, 2'h3};
      default: return '{2'h3, 2'h3};
    endcase
  endfunction

  // Inverse of the above
  function automatic logic [3:0] pair_to_code(input dtg_pair_t p);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (code_to_pair(4'(i)) == p) begin
        c = 4'(i);
      end
    end
    return c;
  endfunction
endpackage

// *** design/dtg_guard_tmr.sv ***
// Purpose: Cycle counter that flags when a run reaches its length
// Assumes: len_i at least 1
// Notes: clr_i restarts the count from zero
`timescale 1ns/1ps
module dtg_guard_tmr
  import dtg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Control
  input wire logic clr_i,
  input wire logic run_i,
  input wire logic [TMR_W-1:0] len_i,
  // Status
  output logic done_o
);
  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;

  // Done must not look at clr_i: callers derive clr_i from done_o
  assign done_o = run_i && (cnt_r == len_i - TMR_W'(1));
  assign cnt_nxt = (clr_i || done_o) ? '0 : (run_i ? cnt_r + TMR_W'(1) : cnt_r);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// *** design/dtg_tone_chan.sv ***
// Purpose: One tone synthesiser channel: segment divider and 32-step phase
// Assumes: seg_len_i at least 1
// Notes: Phase freezes while disabled, so restart has no start-up delay
`timescale 1ns/1ps
module dtg_tone_chan
  import dtg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Control
  input wire logic en_i,
  input wire logic [DIV_W-1:0] seg_len_i,
  // Output
  output logic [PH_W-1:0] phase_o
);
  logic [DIV_W-1:0] seg_r;
  logic [PH_W-1:0] phase_r;
  logic seg_end;

  assign seg_end = en_i && (seg_r >= seg_len_i - DIV_W'(1));
  assign phase_o = phase_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !en_i) begin
      seg_r <= '0;
    end else if (seg_end) begin
      seg_r <= '0; // RULE11
    end else begin
      seg_r <= seg_r + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase_r <= '0;
    end else if (seg_end) begin
      phase_r <= phase_r + PH_W'(1); // RULE11
    end
  end
endmodule

// *** test/dtg_core_sva.sv ***
// Purpose: Port-level checks of the dual-tone core
// Assumes: One clock, synchronous active-high reset
// Notes: Run counters shadow the guard qualification
`timescale 1ns/1ps
module dtg_core_sva
  import dtg_pkg::*;
#(
  parameter int GUARD_PRESENT_N = 8,
  parameter int GUARD_ABSENT_N = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Bus
  input wire logic [1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Receive and tone
  input wire logic tone_present_i,
  input wire logic early_detect_flag_o,
  input wire logic guard_timing_pin_o,
  input wire logic [3:0] rx_code_bits_o,
  input wire logic irq_or_tone_out_oen_o,
  input wire logic [PH_W-1:0] low_phase_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [31:0] on_r;
  logic [31:0] off_r;
  wire stat_rd = avs_read_i && !avs_waitrequest_o && avs_address_i == 2'h1;
  always_ff @(posedge clk_sys_i) begin
    on_r <= (rst_i || !tone_present_i) ? 32'h0 : on_r + 32'h1;
    off_r <= (rst_i || tone_present_i) ? 32'h0 : off_r + 32'h1;
  end
  a_wait_first: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
    else $error("read not held off in its first cycle");
  a_wait_one: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");
  a_early_cause: assert property (early_detect_flag_o |-> tone_present_i)
    else $error("early flag without tone");
  a_early_held: assert property (tone_present_i && guard_timing_pin_o |-> early_detect_flag_o)
    else $error("early flag low with tone");
  a_present_guard: assert property ($rose(guard_timing_pin_o) |-> on_r >= GUARD_PRESENT_N)
    else $error("tone validated too early");
  a_absent_guard: assert property ($fell(guard_timing_pin_o) |-> off_r >= GUARD_ABSENT_N)
    else $error("tone end taken too early");
  a_code_hold: assert property ($changed(rx_code_bits_o) |-> $rose(guard_timing_pin_o))
    else $error("receive code changed without a latch");
  a_irq_clear: assert property (stat_rd && avs_readdata_o[0]
    |=> irq_or_tone_out_oen_o || $rose(guard_timing_pin_o))
    else $error("interrupt not cleared by status read");
  a_steer_read: assert property (stat_rd && $stable(guard_timing_pin_o)
    |-> avs_readdata_o[3] == !guard_timing_pin_o)
    else $error("status steering bit wrong");
  a_phase_step: assert property ($changed(low_phase_o) |-> low_phase_o == $past(low_phase_o) + 5'h1)
    else $error("phase skipped a segment");
endmodule
bind dtg_core dtg_core_sva #(.GUARD_PRESENT_N(GUARD_PRESENT_N), .GUARD_ABSENT_N(GUARD_ABSENT_N)) u_sva (
  .clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_readdata_o, .avs_waitrequest_o, .tone_present_i,
  .early_detect_flag_o, .guard_timing_pin_o, .rx_code_bits_o, .irq_or_tone_out_oen_o, .low_phase_o);

// *** test/dtg_cpu_model.sv ***
// Purpose: Processor on the far side of the register bus
// Assumes: Avalon-MM master, one transfer at a time
// Notes: Waits for the slave; only the bench watchdog ends a hang
`timescale 1ns/1ps
module dtg_cpu_model (
  // Clock
  input wire logic clk_sys_i,
  // Bus to the core
  output logic [1:0] addr_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] wdata_o,
  input wire logic [31:0] rdata_i,
  input wire logic wait_i
);
  initial begin
    addr_o = 2'h0;
    read_o = 1'b0;
    write_o = 1'b0;
    wdata_o = 32'h0;
  end
  task automatic xfer(input logic rd, input logic [1:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    read_o <= rd;
    write_o <= !rd;
    wdata_o <= wd;
    // Request held until a rising edge sees waitrequest low
    @(posedge clk_sys_i);
    while (wait_i !== 1'b0) begin
      @(posedge clk_sys_i);
    end
    d = rdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
  endtask
endmodule

// *** test/test_dual_tone_rx_status_and_tone_gen.sv ***
// Purpose: Self-checking bench of the dual-tone core
// Assumes: Short guard counts so runs stay brief
// Notes: Comparator input high except in the call-progress pin check
`timescale 1ns/1ps
module test_dual_tone_rx_status_and_tone_gen;
  import dtg_pkg::*;
  localparam int GP = 8;
  localparam int GA = 8;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic tone_present_i = 1'b0;
  dtg_pair_t tone_pair_i = '0;
  logic [1:0] adr;
  logic rd_s, wr_s, wait_s, early, steer, oen, lo_on, hi_on, pin_d;
  logic cp_cmp = 1'b1;
  logic [31:0] wdat, rdat;
  logic [3:0] code;
  logic [PH_W-1:0] lo_ph, hi_ph;
  logic [3:0] pairs [3] = '{4'h0, 4'h6, 4'hD};
  logic [3:0] codes [3] = '{4'h1, 4'h6, 4'hA};
  int failures = 0;
  int num_checks = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  dtg_core #(.GUARD_PRESENT_N(GP), .GUARD_ABSENT_N(GA), .BURST_N(16), .BURST_CP_N(20)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_s), .tone_present_i(tone_present_i),
    .tone_pair_i(tone_pair_i), .cp_comparator_i(cp_cmp), .early_detect_flag_o(early), .guard_timing_pin_o(steer),
    .rx_code_bits_o(code), .irq_or_tone_out_o(pin_d), .irq_or_tone_out_oen_o(oen), .low_tone_on_o(lo_on),
    .high_tone_on_o(hi_on), .low_phase_o(lo_ph), .high_phase_o(hi_ph));
  dtg_cpu_model u_cpu (.clk_sys_i(clk_sys_i), .addr_o(adr), .read_o(rd_s), .write_o(wr_s), .wdata_o(wdat),
    .rdata_i(rdat), .wait_i(wait_s));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_cpu.xfer(1'b1, a, 32'h0, d);
    check(d, exp);
  endtask
  task automatic wr(input logic [1:0] a, input logic [31:0] v);
    logic [31:0] d;
    u_cpu.xfer(1'b0, a, v, d);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Cycles between two phase steps of one channel
  task automatic meas(input logic ch, input int idx);
    int n;
    logic [PH_W-1:0] p;
    longint f;
    f = FREQ_DHZ[idx];
    @(negedge clk_sys_i);
    p = ch ? hi_ph : lo_ph;
    n = 0;
    while ((ch ? hi_ph : lo_ph) === p && n < 20000) begin
      @(negedge clk_sys_i);
      n++;
    end
    p = ch ? hi_ph : lo_ph;
    n = 0;
    while ((ch ? hi_ph : lo_ph) === p && n < 20000) begin
      @(negedge clk_sys_i);
      n++;
    end
    check(n, 32'((longint'(CLK_HZ) * 10 + 16 * f) / (32 * f)));
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Whole run is near 24k cycles
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    failures++;
    give_verdict();
  end
  initial begin
    wait_n(2);
    rst_i <= 1'b0;
    rd(2'h1, 32'h8);
    rd(2'h0, 32'h0);
    rd(2'h3, 32'h0);
    wr(2'h1, 32'h4);
    wr(2'h2, 32'h3F);
    rd(2'h2, 32'h4);
    // Too short to qualify
    tone_pair_i <= '{2'h0, 2'h0};
    tone_present_i <= 1'b1;
    wait_n(GP - 2);
    tone_present_i <= 1'b0;
    wait_n(GA + 4);
    rd(2'h1, 32'h8);
    rd(2'h0, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(2'h1, (i == 0) ? 32'h0 : 32'h4);
      tone_pair_i <= dtg_pair_t'(pairs[i]);
      tone_present_i <= 1'b1;
      wait_n(GP + 4);
      @(negedge clk_sys_i);
      check({oen, early, steer}, {i == 0, 2'b11});
      rd(2'h1, (i == 0) ? 32'h4 : 32'h5);
      rd(2'h0, 32'(codes[i]));
      rd(2'h1, 32'h0);
      check(oen, 32'h1);
      if (i == 1) begin
        tone_present_i <= 1'b0;
        wait_n(GA - 4);
        tone_present_i <= 1'b1;
        wait_n(GP + 4);
        rd(2'h1, 32'h0);
      end
      tone_present_i <= 1'b0;
      wait_n(GA + 4);
      rd(2'h1, 32'h8);
      rd(2'h0, 32'(codes[i]));
    end
    // Status read taken at the very latch edge
    tone_pair_i <= '{2'h2, 2'h1};
    tone_present_i <= 1'b1;
    wait_n(GP - 2);
    rd(2'h1, 32'h8);
    rd(2'h1, 32'h5);
    rd(2'h0, 32'h8);
    tone_present_i <= 1'b0;
    wait_n(GA + 4);
    wr(2'h1, 32'h6);
    tone_present_i <= 1'b1;
    wait_n(GP + 4);
    @(negedge clk_sys_i);
    check(early, 32'h0);
    check({oen, pin_d}, 32'h2);
    @(posedge clk_sys_i);
    cp_cmp <= 1'b0;
    @(negedge clk_sys_i);
    check(oen, 32'h0);
    @(posedge clk_sys_i);
    cp_cmp <= 1'b1;
    rd(2'h1, 32'h8);
    tone_present_i <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      wr(2'h1, (j == 0) ? 32'h01 : (j == 1) ? 32'h11 : 32'h31);
      wr(2'h0, 32'h5);
      @(negedge clk_sys_i);
      check({lo_on, hi_on}, 3 - j);
    end
    // Burst: tone, pause, then transmitter ready raises the interrupt
    wr(2'h1, 32'h0D);
    wr(2'h0, 32'h5);
    @(negedge clk_sys_i);
    check({lo_on, hi_on, oen}, 32'h7);
    wait_n(40);
    @(negedge clk_sys_i);
    check({lo_on, hi_on, oen}, 32'h0);
    rd(2'h1, 32'hB);
    rd(2'h1, 32'h8);
    wr(2'h1, 32'h01);
    meas(1'b0, 1);
    meas(1'b1, 5);
    give_verdict();
  end
endmodule
